// *** logic/dma_status_pkg.sv ***
// Package with register map, field positions, reset values and event carriers of the DMA status block.
package dma_status_pkg;
  localparam logic [7:0] OFF_TX_QUEUE_PTR = 8'h00;
  localparam logic [7:0] OFF_RX_STATUS = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_INT_DISABLE = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_TX_STATUS = 8'h18;
  localparam int RX_BNA_BIT = 0;
  localparam int RX_REC_BIT = 1;
  localparam int RX_OVR_BIT = 2;
  localparam int TX_ACTIVE_BIT = 3;
  localparam int DESC_SHIFT = 3;
  localparam int DESC_IDX_W = 10;
  localparam logic [9:0] DESC_IDX_LAST = 10'h3ff;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [2:0] RX_STATUS_RESET = 3'h0;
  localparam logic [13:0] INT_STATUS_RESET = 14'h0000;
  localparam logic [13:0] INT_MASK_RESET = 14'h3cff;
  localparam logic [13:0] INT_VALID = 14'h3cff;

  // Event pulses from the DMA engine and MAC, packed in interrupt status bit order.
  typedef struct packed {
    logic pause_zero;
    logic pause_received;
    logic bus_error;
    logic receive_overrun;
    logic rsvd9;
    logic rsvd8;
    logic transmit_complete;
    logic transmit_error;
    logic retry_limit;
    logic transmit_underrun;
    logic transmit_used_read;
    logic receive_used_read;
    logic receive_complete;
    logic management_done;
  } int_events_t;

  // Descriptor walk and receive DMA events.
  typedef struct packed {
    logic tx_buf_used;
    logic tx_buf_wrap;
    logic tx_frame_done;
    logic rx_frame_start;
    logic rx_fetch_fail;
    logic rx_fetch_ok;
    logic rx_frame_stored;
  } dma_events_t;
endpackage

// *** logic/dma_status_regs.sv ***
// DMA status, queue pointer and interrupt registers of the MAC, on an Avalon-MM slave.
//
// Operation
// - Software loads tx pointer; device walks descriptors.
// - Index increments per buffer; wraps at 1024/wrap.
// - Pointer writes accepted only while transmit inactive.
// - Transmit active flag shown in tx status.
// - Pointer read gives current frame's first buffer.
// - Receive status bits clear by writing one.
// - Every failed receive buffer fetch sets bna.
// - After failure, refetch at each frame start.
// - Frame received flag set on stored frame.
// - Overrun sets flag and reclaims buffer.
// - Interrupt status bit layout fixed.
// - Management done sets flag; read clears reported flags.
// - Stored frame sets receive complete.
// - Used descriptor read sets used-read flag.
// - Underrun on late, error, used, pointer write.
// - Buffers exhausted mid-frame sets transmit error.
// - Whole frame transmitted sets transmit complete.
// - Receive overrun status sets overrun interrupt.
// - Bus error response sets bus-error flag.
// - Valid pause frame sets pause received.
// - Pause counter reaching zero sets pause zero.
// - Enable write of one unmasks source.
// - Disable write of one masks source.
// - Mask register shows masked sources.
`timescale 1ns/1ps
module dma_status_regs (
  input wire logic clk, // 100 MHz system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [7:0] address, // Avalon byte address
  input wire logic read, // Avalon read request
  input wire logic write, // Avalon write request
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire dma_status_pkg::int_events_t int_ev, // interrupt source pulses
  input wire dma_status_pkg::dma_events_t dma_ev, // descriptor walk pulses
  input wire logic transmit_active, // transmitter is sending
  output logic [31:0] tx_desc_addr, // descriptor the tx DMA uses now
  output logic rx_refetch, // pulse: reread rx descriptor
  output logic rx_reclaim, // pulse: recover the rx buffer
  output logic irq // interrupt request, active high
);
  import dma_status_pkg::*;

  logic [31:0] base_q;
  logic [9:0] idx_q;
  logic [9:0] frame_idx_q;
  logic [2:0] rx_status_q;
  logic [13:0] int_status_q;
  logic [13:0] mask_q;
  logic tx_active_q;
  logic bna_pending_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic refetch_q;
  logic reclaim_q;
  logic irq_q;
  logic [31:0] addr_q;
  logic access;
  logic wr;
  logic rd;
  logic [31:0] wdata;
  logic [13:0] int_set;
  logic [2:0] rx_set;
  logic ptr_write;
  logic [31:0] rd_value;

  // The access completes at the edge where waitrequest is sampled low.
  assign access = (read | write) & ~wait_q;
  assign wr = access & write;
  assign rd = access & read;
  // Byte lanes that are not enabled write as zero except to the queue pointer, so they never clear or unmask.
  assign wdata = writedata & {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign ptr_write = wr && address == OFF_TX_QUEUE_PTR && !tx_active_q;

  // One wait state: read data is captured at the first edge and stands at the completing edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else if ((read | write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    case (address)
      OFF_TX_QUEUE_PTR: rd_value = base_q + {19'h0, frame_idx_q, 3'h0};
      OFF_RX_STATUS: rd_value = {29'h0, rx_status_q};
      OFF_INT_STATUS: rd_value = {18'h0, int_status_q};
      OFF_INT_MASK: rd_value = {18'h0, mask_q};
      OFF_TX_STATUS: rd_value = {28'h0, tx_active_q, 3'h0};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      rdata_q <= rd_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_active_q <= 1'b0;
    end else begin
      tx_active_q <= transmit_active;
    end
  end

  // Queue pointer: the written base is kept so the wrap returns to it exactly.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      base_q <= PTR_RESET;
    end else if (ptr_write) begin
      base_q <= writedata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      idx_q <= 10'h000;
      frame_idx_q <= 10'h000;
    end else if (ptr_write) begin
      idx_q <= 10'h000;
      frame_idx_q <= 10'h000;
    end else begin
      if (dma_ev.tx_buf_used) begin
        if (dma_ev.tx_buf_wrap || idx_q == DESC_IDX_LAST) begin
          idx_q <= 10'h000;
        end else begin
          idx_q <= idx_q + 10'h001;
        end
      end
      if (dma_ev.tx_frame_done) begin
        if (dma_ev.tx_buf_used) begin
          frame_idx_q <= (dma_ev.tx_buf_wrap || idx_q == DESC_IDX_LAST) ? 10'h000 : idx_q + 10'h001;
        end else begin
          frame_idx_q <= idx_q;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= PTR_RESET;
    end else begin
      addr_q <= base_q + {19'h0, idx_q, 3'h0};
    end
  end

  // Receive status: hardware set wins over a simultaneous write-one clear.
  assign rx_set = {int_ev.receive_overrun, dma_ev.rx_frame_stored, dma_ev.rx_fetch_fail};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_status_q <= RX_STATUS_RESET;
    end else if (wr && address == OFF_RX_STATUS) begin
      rx_status_q <= (rx_status_q & ~wdata[2:0]) | rx_set;
    end else begin
      rx_status_q <= rx_status_q | rx_set;
    end
  end

  // A failed fetch leaves the receive DMA waiting; it rereads at every new frame.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bna_pending_q <= 1'b0;
    end else if (dma_ev.rx_fetch_fail) begin
      bna_pending_q <= 1'b1;
    end else if (dma_ev.rx_fetch_ok) begin
      bna_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      refetch_q <= 1'b0;
      reclaim_q <= 1'b0;
    end else begin
      refetch_q <= bna_pending_q & dma_ev.rx_frame_start;
      reclaim_q <= int_ev.receive_overrun;
    end
  end

  // Interrupt status: only bits returned by the read are cleared, so an event
  // that lands between capture and completion is kept.
  always_comb begin
    int_set = int_ev & INT_VALID;
    int_set[RX_OVR_BIT + 8] = int_ev.receive_overrun | rx_set[RX_OVR_BIT];
    int_set[4] = int_ev.transmit_underrun | ptr_write;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_status_q <= INT_STATUS_RESET;
    end else if (rd && address == OFF_INT_STATUS) begin
      int_status_q <= (int_status_q & ~rdata_q[13:0]) | int_set;
    end else begin
      int_status_q <= int_status_q | int_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= INT_MASK_RESET;
    end else if (wr && address == OFF_INT_ENABLE) begin
      mask_q <= mask_q & ~(wdata[13:0] & INT_VALID);
    end else if (wr && address == OFF_INT_DISABLE) begin
      mask_q <= mask_q | (wdata[13:0] & INT_VALID);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_status_q & ~mask_q);
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign tx_desc_addr = addr_q;
  assign rx_refetch = refetch_q;
  assign rx_reclaim = reclaim_q;
  assign irq = irq_q;

  sequence s_write_at(logic [7:0] a);
    write && !wait_q && address == a;
  endsequence

  property p_ptr_locked;
    @(posedge clk) disable iff (!rstn)
      s_write_at(OFF_TX_QUEUE_PTR) and tx_active_q |=> $stable(base_q);
  endproperty
  a_ptr_locked: assert property (p_ptr_locked) else $error("pointer changed while transmitting");

  property p_ptr_load;
    @(posedge clk) disable iff (!rstn)
      ptr_write |=> base_q == $past(writedata) && idx_q == 10'h000 ##1 tx_desc_addr == base_q;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");

  property p_idx_step;
    @(posedge clk) disable iff (!rstn)
      dma_ev.tx_buf_used && !dma_ev.tx_buf_wrap && idx_q != DESC_IDX_LAST && !ptr_write
      |=> idx_q == $past(idx_q) + 10'h001;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("descriptor index did not step");

  property p_idx_wrap;
    @(posedge clk) disable iff (!rstn)
      dma_ev.tx_buf_used && (dma_ev.tx_buf_wrap || idx_q == DESC_IDX_LAST) |=> idx_q == 10'h000;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("descriptor index did not wrap");

  property p_bna_set;
    @(posedge clk) disable iff (!rstn)
      dma_ev.rx_fetch_fail |=> rx_status_q[RX_BNA_BIT] && bna_pending_q;
  endproperty
  a_bna_set: assert property (p_bna_set) else $error("buffer not available not set");

  property p_refetch;
    @(posedge clk) disable iff (!rstn)
      bna_pending_q && dma_ev.rx_frame_start |=> rx_refetch;
  endproperty
  a_refetch: assert property (p_refetch) else $error("no refetch at frame start");

  property p_w1c_no_set;
    @(posedge clk) disable iff (!rstn)
      s_write_at(OFF_RX_STATUS) and rx_set == 3'h0 |=> (rx_status_q & ~$past(rx_status_q)) == 3'h0;
  endproperty
  a_w1c_no_set: assert property (p_w1c_no_set) else $error("write set a receive status bit");

  property p_ovr_chain;
    @(posedge clk) disable iff (!rstn)
      int_ev.receive_overrun |=> rx_status_q[RX_OVR_BIT] && int_status_q[10] && rx_reclaim;
  endproperty
  a_ovr_chain: assert property (p_ovr_chain) else $error("overrun not flagged or reclaimed");

  property p_read_clears;
    @(posedge clk) disable iff (!rstn)
      rd && address == OFF_INT_STATUS && int_set == 14'h0000 |=> (int_status_q & $past(rdata_q[13:0])) == 14'h0000;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_underrun_on_load;
    @(posedge clk) disable iff (!rstn)
      ptr_write |=> int_status_q[4];
  endproperty
  a_underrun_on_load: assert property (p_underrun_on_load) else $error("pointer write did not flag underrun");

  property p_mask_enable;
    @(posedge clk) disable iff (!rstn)
      s_write_at(OFF_INT_ENABLE) |=> (mask_q & $past(wdata[13:0])) == 14'h0000
        && (mask_q & ~$past(wdata[13:0])) == ($past(mask_q) & ~$past(wdata[13:0]));
  endproperty
  a_mask_enable: assert property (p_mask_enable) else $error("enable write wrong");

  property p_mask_disable;
    @(posedge clk) disable iff (!rstn)
      s_write_at(OFF_INT_DISABLE) |=> (mask_q & $past(wdata[13:0] & INT_VALID)) == $past(wdata[13:0] & INT_VALID);
  endproperty
  a_mask_disable: assert property (p_mask_disable) else $error("disable write wrong");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
      |(int_status_q & ~mask_q) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge clk) disable iff (!rstn)
      (int_status_q & ~mask_q) == 14'h0000 |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  property p_tx_active_copy;
    @(posedge clk) disable iff (!rstn)
      transmit_active |=> tx_active_q;
  endproperty
  a_tx_active_copy: assert property (p_tx_active_copy) else $error("transmit active not shown");

  property p_frame_start;
    @(posedge clk) disable iff (!rstn)
      dma_ev.tx_frame_done && !dma_ev.tx_buf_used && !ptr_write |=> frame_idx_q == $past(idx_q);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start index not taken");

  property p_rec_set;
    @(posedge clk) disable iff (!rstn)
      dma_ev.rx_frame_stored |=> rx_status_q[RX_REC_BIT];
  endproperty
  a_rec_set: assert property (p_rec_set) else $error("frame received not set");

  // A pulse must never be lost, even when a status read completes in the same cycle.
  property p_event_capture;
    @(posedge clk) disable iff (!rstn)
      (int_ev & INT_VALID) != 14'h0000
      |=> (int_status_q & $past(int_ev & INT_VALID)) == $past(int_ev & INT_VALID);
  endproperty
  a_event_capture: assert property (p_event_capture) else $error("interrupt event lost");

  property p_flags_held;
    @(posedge clk) disable iff (!rstn)
      !(rd && address == OFF_INT_STATUS) |=> (int_status_q & $past(int_status_q)) == $past(int_status_q);
  endproperty
  a_flags_held: assert property (p_flags_held) else $error("interrupt flag lost without read");

  property p_rx_held;
    @(posedge clk) disable iff (!rstn)
      !(wr && address == OFF_RX_STATUS) |=> (rx_status_q & $past(rx_status_q)) == $past(rx_status_q);
  endproperty
  a_rx_held: assert property (p_rx_held) else $error("receive status lost without write");

  property p_refetch_idle;
    @(posedge clk) disable iff (!rstn)
      !bna_pending_q |=> !rx_refetch;
  endproperty
  a_refetch_idle: assert property (p_refetch_idle) else $error("refetch without failure");

  property p_one_wait;
    @(posedge clk) disable iff (!rstn)
      (read || write) && wait_q |=> !waitrequest ##1 waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait state");
endmodule

// *** verification/dma_event_model.sv ***
// Event source model standing in for the DMA engine and MAC around the status block.
`timescale 1ns/1ps
module dma_event_model (
  input wire logic clk, // system clock
  output dma_status_pkg::int_events_t int_ev, // interrupt source pulses
  output dma_status_pkg::dma_events_t dma_ev, // descriptor walk pulses
  output logic transmit_active // transmitter is sending
);
  import dma_status_pkg::*;
  logic [13:0] iv = '0;
  logic [6:0] dv = '0;
  initial transmit_active = 1'b0;
  assign int_ev = int_events_t'(iv);
  assign dma_ev = dma_events_t'(dv);
  // Events last exactly one cycle, so a slow clear in the block cannot hide a missed capture.
  task automatic pulse_int(input int idx);
    @(posedge clk);
    iv <= 14'h1 << idx;
    @(posedge clk);
    iv <= '0;
  endtask
  task automatic pulse_dma(input logic [6:0] m);
    @(posedge clk);
    dv <= m;
    @(posedge clk);
    dv <= '0;
  endtask
  task automatic set_active(input logic a);
    @(posedge clk);
    transmit_active <= a;
  endtask
endmodule

// *** verification/tb_mac_dma_status_interrupts.sv ***
// Self-checking bench of the DMA status, queue pointer and interrupt registers.
`timescale 1ns/1ps
module tb_mac_dma_status_interrupts;
  import dma_status_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [3:0] lanes = 4'hf;
  logic [31:0] readdata, tx_desc_addr, rd;
  logic waitrequest, rx_refetch, rx_reclaim, irq, transmit_active;
  int_events_t int_ev;
  dma_events_t dma_ev;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  dma_event_model dma_event_model_inst (.clk(clk), .int_ev(int_ev), .dma_ev(dma_ev),
    .transmit_active(transmit_active));
  dma_status_regs dma_status_regs_inst (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .int_ev(int_ev), .dma_ev(dma_ev), .transmit_active(transmit_active),
    .tx_desc_addr(tx_desc_addr), .rx_refetch(rx_refetch), .rx_reclaim(rx_reclaim), .irq(irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The walk through all 1024 descriptors dominates the run time.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; the request stands until waitrequest is sampled low, and only the bench timeout ends a hang.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    byteenable <= lanes;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdchk(OFF_INT_MASK, 32'(INT_MASK_RESET), "mask reset");
    rdchk(OFF_INT_STATUS, 32'h0, "int status reset");
    rdchk(OFF_RX_STATUS, 32'h0, "rx status reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    bus(1'b1, OFF_INT_MASK, 32'h0);
    rdchk(OFF_INT_MASK, 32'(INT_MASK_RESET), "mask read only");
    for (int i = 0; i < 14; i++) begin
      dma_event_model_inst.pulse_int(i);
      rdchk(OFF_INT_STATUS, INT_VALID[i] ? 32'h1 << i : 32'h0, "int status bit");
      rdchk(OFF_INT_STATUS, 32'h0, "cleared on read");
      chk("irq masked", 32'h0, {31'h0, irq});
    end
    dma_event_model_inst.pulse_int(7);
    repeat (3) @(posedge clk);
    chk("irq while masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_INT_ENABLE, 32'h80);
    rdchk(OFF_INT_MASK, 32'h3c7f, "mask after enable");
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_INT_ENABLE, 32'h0);
    bus(1'b1, OFF_INT_DISABLE, 32'h0);
    rdchk(OFF_INT_MASK, 32'h3c7f, "mask zero write");
    // Only lane 1 enabled: bit 10 is unmasked, bit 0 in the dead lane stays masked.
    lanes = 4'h2;
    bus(1'b1, OFF_INT_ENABLE, 32'h0401);
    lanes = 4'hf;
    rdchk(OFF_INT_MASK, 32'h387f, "mask lane enable");
    bus(1'b1, OFF_INT_DISABLE, 32'h0400);
    bus(1'b1, OFF_INT_DISABLE, 32'h80);
    rdchk(OFF_INT_MASK, 32'h3cff, "mask after disable");
    chk("irq masked again", 32'h0, {31'h0, irq});
    rdchk(OFF_INT_STATUS, 32'h80, "flag kept while masked");
    bus(1'b1, OFF_RX_STATUS, 32'h7);
    dma_event_model_inst.pulse_dma(7'h04);
    bus(1'b1, OFF_RX_STATUS, 32'h1);
    dma_event_model_inst.pulse_dma(7'h04);
    rdchk(OFF_RX_STATUS, 32'h1, "bna set again");
    dma_event_model_inst.pulse_dma(7'h08);
    #1 chk("refetch", 32'h1, {31'h0, rx_refetch});
    dma_event_model_inst.pulse_dma(7'h02);
    dma_event_model_inst.pulse_dma(7'h08);
    #1 chk("no refetch after success", 32'h0, {31'h0, rx_refetch});
    dma_event_model_inst.pulse_dma(7'h01);
    dma_event_model_inst.pulse_int(10);
    #1 chk("reclaim", 32'h1, {31'h0, rx_reclaim});
    rdchk(OFF_RX_STATUS, 32'h7, "rx status all");
    rdchk(OFF_INT_STATUS, 32'h400, "overrun interrupt");
    bus(1'b1, OFF_RX_STATUS, 32'h2);
    bus(1'b1, OFF_RX_STATUS, 32'h0);
    rdchk(OFF_RX_STATUS, 32'h5, "write one clears");
    bus(1'b1, OFF_TX_QUEUE_PTR, 32'h1000);
    rdchk(OFF_TX_QUEUE_PTR, 32'h1000, "queue pointer");
    chk("descriptor address", 32'h1000, tx_desc_addr);
    rdchk(OFF_INT_STATUS, 32'h10, "underrun on pointer write");
    for (int i = 1; i <= 1024; i++) begin
      dma_event_model_inst.pulse_dma(7'h40);
      @(posedge clk);
      #1 chk("descriptor walk", 32'h1000 + 32'((i % 1024) * 8), tx_desc_addr);
    end
    dma_event_model_inst.pulse_dma(7'h40);
    dma_event_model_inst.pulse_dma(7'h60);
    @(posedge clk);
    #1 chk("wrap flag", 32'h1000, tx_desc_addr);
    rdchk(OFF_TX_QUEUE_PTR, 32'h1000, "frame start pointer");
    dma_event_model_inst.pulse_dma(7'h40);
    dma_event_model_inst.pulse_dma(7'h10);
    rdchk(OFF_TX_QUEUE_PTR, 32'h1008, "pointer after frame");
    dma_event_model_inst.pulse_dma(7'h50);
    rdchk(OFF_TX_QUEUE_PTR, 32'h1010, "pointer after last buffer");
    chk("descriptor after frame", 32'h1010, tx_desc_addr);
    dma_event_model_inst.set_active(1'b1);
    rdchk(OFF_TX_STATUS, 32'h8, "transmit active");
    bus(1'b1, OFF_TX_QUEUE_PTR, 32'h2000);
    rdchk(OFF_TX_QUEUE_PTR, 32'h1010, "write while active");
    rdchk(OFF_INT_STATUS, 32'h0, "no underrun when refused");
    // A reset in mid-run must bring pointer, mask, interrupt status, descriptor address and irq back, even with the transmitter busy.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdchk(OFF_TX_QUEUE_PTR, PTR_RESET, "pointer after reset");
    rdchk(OFF_INT_MASK, 32'(INT_MASK_RESET), "mask after reset");
    rdchk(OFF_INT_STATUS, 32'h0, "int status after reset");
    chk("descriptor after reset", PTR_RESET, tx_desc_addr);
    chk("irq after reset", 32'h0, {31'h0, irq});
    give_verdict();
  end
endmodule
